/* File: core/cbt_pkg.sv */
package cbt_pkg;
   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_TIMING  = 4'h0;
   localparam logic [3:0] OFS_MASK_UP = 4'h2;
   localparam logic [3:0] OFS_MASK_LO = 4'h4;
   localparam logic [3:0] OFS_STATUS  = 4'h6;

   // reset values
   localparam logic [15:0] TIMING_RST = 16'h0000;
   localparam logic [15:0] MASK_RST   = 16'h0000;

   // bit_timing_config field positions
   localparam int PSC_LSB = 9;
   localparam int PSC_W   = 7;
   localparam int SJW_LSB = 7;
   localparam int SJW_W   = 2;
   localparam int TS1_LSB = 3;
   localparam int TS1_W   = 4;
   localparam int TS2_LSB = 0;
   localparam int TS2_W   = 3;

   // prescaler coding: factor = code + 2, top two codes give the ceiling
   localparam logic [6:0] PSC_CAP_CODE   = 7'h7E;
   localparam logic [7:0] PSC_MAX_FACTOR = 8'h80;
   localparam logic [7:0] PSC_OFFSET     = 8'h02;

   // status register bit positions
   localparam int ST_SEG_LSB = 0;
   localparam int ST_ACCEPT  = 2;
   localparam int ST_RXBIT   = 3;

   // 32-bit global_accept_mask layout (upper register in 31:16)
   localparam int ID_W = 29;
   localparam logic [31:0] STD_USED = 32'hFFF8_0000;
   localparam logic [31:0] EXT_USED = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      SEG_SYNC = 2'b00,
      SEG_ONE  = 2'b01,
      SEG_TWO  = 2'b10
   } cbt_seg_type;

   // order: id 28..18, first remote, ide, id 17..0, extended remote
   function automatic logic [31:0] cbt_pack(input logic [28:0] id, input logic ide,
                                            input logic rtr, input logic extended_remote_mask);
      cbt_pack = {id[28:18], rtr, ide, id[17:0], extended_remote_mask};
   endfunction
endpackage

/* File: core/cbt_bit_timer.sv */
`timescale 1ns/1ps
module cbt_bit_timer (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic [6:0]        psc_code,
   input  wire logic [1:0]        sjw_code,
   input  wire logic [3:0]        ts1_code,
   input  wire logic [2:0]        ts2_code,
   input  wire logic              rx_fall,
   output logic                   tq_tick,
   output logic                   sample_pt,
   output cbt_pkg::cbt_seg_type   seg
);
   logic [7:0]           factor;
   logic [7:0]           pcnt_q, pcnt_d;
   logic [5:0]           len1, len2, sjw_len, rem2;
   logic [5:0]           qcnt_q, qcnt_d, ext_q, ext_d, cut_q, cut_d;
   logic                 done_q, done_d;
   cbt_pkg::cbt_seg_type seg_q, seg_d;

   // quantum length in clocks, two top codes saturate
   assign factor  = (psc_code >= cbt_pkg::PSC_CAP_CODE) ? cbt_pkg::PSC_MAX_FACTOR
                                                        : {1'b0, psc_code} + cbt_pkg::PSC_OFFSET;
   assign tq_tick = (pcnt_q == factor - 8'h01);
   assign len1    = {2'b00, ts1_code} + 6'h01;
   assign len2    = {3'b000, ts2_code} + 6'h01;
   assign sjw_len = {4'b0000, sjw_code} + 6'h01;
   assign rem2    = len2 - qcnt_q;
   assign seg     = seg_q;

   // segment sequencer; one resync per bit, edge in sync quantum needs none
   always_comb begin
      pcnt_d    = tq_tick ? 8'h00 : pcnt_q + 8'h01;
      seg_d     = seg_q;
      qcnt_d    = qcnt_q;
      ext_d     = ext_q;
      cut_d     = cut_q;
      done_d    = done_q;
      sample_pt = 1'b0;
      if (rx_fall && !done_q && seg_q == cbt_pkg::SEG_ONE) begin
         // late edge: stretch segment one by the error, at most the jump width
         ext_d  = (qcnt_q + 6'h01 < sjw_len) ? qcnt_q + 6'h01 : sjw_len;
         done_d = 1'b1;
      end
      if (rx_fall && !done_q && seg_q == cbt_pkg::SEG_TWO) begin
         // early edge: trim segment two, never below the current quantum
         cut_d  = (rem2 <= sjw_len) ? rem2 - 6'h01 : sjw_len;
         done_d = 1'b1;
      end
      if (tq_tick) begin
         unique case (seg_q)
            cbt_pkg::SEG_SYNC: begin
               seg_d  = cbt_pkg::SEG_ONE;
               qcnt_d = 6'h00;
            end
            cbt_pkg::SEG_ONE: begin
               if (qcnt_q + 6'h01 >= len1 + ext_d) begin
                  seg_d     = cbt_pkg::SEG_TWO;
                  qcnt_d    = 6'h00;
                  sample_pt = 1'b1;
               end else begin
                  qcnt_d = qcnt_q + 6'h01;
               end
            end
            cbt_pkg::SEG_TWO: begin
               if (qcnt_q + 6'h01 >= len2 - cut_d) begin
                  seg_d  = cbt_pkg::SEG_SYNC;
                  qcnt_d = 6'h00;
                  ext_d  = 6'h00;
                  cut_d  = 6'h00;
                  done_d = 1'b0;
               end else begin
                  qcnt_d = qcnt_q + 6'h01;
               end
            end
            default: seg_d = cbt_pkg::SEG_SYNC;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcnt_q <= 8'h00;
         seg_q  <= cbt_pkg::SEG_SYNC;
         qcnt_q <= 6'h00;
         ext_q  <= 6'h00;
         cut_q  <= 6'h00;
         done_q <= 1'b0;
      end else begin
         pcnt_q <= pcnt_d;
         seg_q  <= seg_d;
         qcnt_q <= qcnt_d;
         ext_q  <= ext_d;
         cut_q  <= cut_d;
         done_q <= done_d;
      end
   end
endmodule // cbt_bit_timer

/* File: core/cbt_accept_filter.sv */
`timescale 1ns/1ps
module cbt_accept_filter (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] mask,
   input  wire logic        cmp_valid,
   input  wire logic [31:0] in_vec,
   input  wire logic [31:0] buf_vec,
   input  wire logic        in_ide,
   output logic             acc_valid,
   output logic             accept,
   output logic [31:0]      merged
);
   logic [31:0] used, sel, ok, merge_d, merged_q;
   logic        valid_q, accept_q, accept_d;

   // ide picks the frame type and thus which mask bits apply
   assign used = in_ide ? cbt_pkg::EXT_USED : cbt_pkg::STD_USED;
   assign sel  = used & mask;

   // per bit: unused or masked passes, else must equal the buffer
   for (genvar i = 0; i < 32; i++) begin : g_bit
      assign ok[i]      = ~used[i] | mask[i] | (in_vec[i] == buf_vec[i]);
      assign merge_d[i] = sel[i] ? in_vec[i] : buf_vec[i];
   end
   assign accept_d = &ok;

   assign acc_valid = valid_q;
   assign accept    = accept_q;
   assign merged    = merged_q;

   // result registered, one cycle after the compare strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q  <= 1'b0;
         accept_q <= 1'b0;
         merged_q <= 32'h0000_0000;
      end else begin
         valid_q  <= cmp_valid;
         accept_q <= cmp_valid ? accept_d : accept_q;
         merged_q <= (cmp_valid && accept_d) ? merge_d : merged_q;
      end
   end
endmodule // cbt_accept_filter

/* File: core/cbt_core.sv */
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cbt_core (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   input  wire logic        can_rx,
   output logic             tq_tick,
   output logic             sample_pt,
   output logic             rx_bit,
   input  wire logic        cmp_valid,
   input  wire logic [28:0] rx_id,
   input  wire logic        rx_ide,
   input  wire logic        rx_rtr,
   input  wire logic        rx_extended_remote_mask,
   input  wire logic [28:0] buf_id,
   input  wire logic        buf_ide,
   input  wire logic        buf_rtr,
   input  wire logic        buf_extended_remote_mask,
   output logic             acc_valid,
   output logic             accept,
   output logic [28:0]      merged_id,
   output logic             merged_ide,
   output logic             merged_rtr,
   output logic             merged_extended_remote_mask
);
   logic                 rst_s1_q, rst_n;
   logic                 rx_s1_q, rx_s2_q, rx_prev_q, rx_bit_q, rx_bit_d, rx_fall;
   logic [15:0]          timing_q, timing_d, mask_up_q, mask_up_d, mask_lo_q, mask_lo_d;
   logic [15:0]          rdata_q, rdata_d, status;
   logic [31:0]          gmask, in_vec, buf_vec, merged;
   cbt_pkg::cbt_seg_type seg;

   // reset release through two flops; assertion is immediate, release is clean
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // bus pin synchroniser; only the second stage feeds the edge detector
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_s1_q   <= 1'b1;
         rx_s2_q   <= 1'b1;
         rx_prev_q <= 1'b1;
         rx_bit_q  <= 1'b1;
      end else begin
         rx_s1_q   <= can_rx;
         rx_s2_q   <= rx_s1_q;
         rx_prev_q <= rx_s2_q;
         rx_bit_q  <= rx_bit_d;
      end
   end

   // recessive to dominant transition drives resynchronisation
   assign rx_fall  = rx_prev_q & ~rx_s2_q;
   assign rx_bit_d = sample_pt ? rx_s2_q : rx_bit_q;
   assign rx_bit   = rx_bit_q;

   // register writes; reads return the stored word a cycle later
   always_comb begin
      timing_d  = timing_q;
      mask_up_d = mask_up_q;
      mask_lo_d = mask_lo_q;
      rdata_d   = 16'h0000;
      if (reg_wr) begin
         unique case (reg_addr)
            cbt_pkg::OFS_TIMING:  timing_d  = reg_wdata;
            cbt_pkg::OFS_MASK_UP: mask_up_d = reg_wdata;
            cbt_pkg::OFS_MASK_LO: mask_lo_d = reg_wdata;
            default:              timing_d  = timing_q;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            cbt_pkg::OFS_TIMING:  rdata_d = timing_q;
            cbt_pkg::OFS_MASK_UP: rdata_d = mask_up_q;
            cbt_pkg::OFS_MASK_LO: rdata_d = mask_lo_q;
            cbt_pkg::OFS_STATUS:  rdata_d = status;
            default:              rdata_d = 16'h0000; // unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timing_q  <= cbt_pkg::TIMING_RST;
         mask_up_q <= cbt_pkg::MASK_RST;
         mask_lo_q <= cbt_pkg::MASK_RST;
         rdata_q   <= 16'h0000;
      end else begin
         timing_q  <= timing_d;
         mask_up_q <= mask_up_d;
         mask_lo_q <= mask_lo_d;
         rdata_q   <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   // live state for software: segment, last accept result, last sampled bit
   always_comb begin
      status                                = 16'h0000;
      status[cbt_pkg::ST_SEG_LSB +: 2]      = seg;
      status[cbt_pkg::ST_ACCEPT]            = accept;
      status[cbt_pkg::ST_RXBIT]             = rx_bit_q;
   end

   // two halves seen as a single mask word
   assign gmask   = {mask_up_q, mask_lo_q};
   assign in_vec  = cbt_pkg::cbt_pack(rx_id, rx_ide, rx_rtr, rx_extended_remote_mask);
   assign buf_vec = cbt_pkg::cbt_pack(buf_id, buf_ide, buf_rtr, buf_extended_remote_mask);

   cbt_bit_timer u_timer (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .psc_code  (timing_q[cbt_pkg::PSC_LSB +: cbt_pkg::PSC_W]),
      .sjw_code  (timing_q[cbt_pkg::SJW_LSB +: cbt_pkg::SJW_W]),
      .ts1_code  (timing_q[cbt_pkg::TS1_LSB +: cbt_pkg::TS1_W]),
      .ts2_code  (timing_q[cbt_pkg::TS2_LSB +: cbt_pkg::TS2_W]),
      .rx_fall   (rx_fall),
      .tq_tick   (tq_tick),
      .sample_pt (sample_pt),
      .seg       (seg)
   );

   cbt_accept_filter u_filter (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .mask      (gmask),
      .cmp_valid (cmp_valid),
      .in_vec    (in_vec),
      .buf_vec   (buf_vec),
      .in_ide    (rx_ide),
      .acc_valid (acc_valid),
      .accept    (accept),
      .merged    (merged)
   );

   // unpack merged word back into buffer fields
   assign merged_id   = {merged[31:21], merged[18:1]};
   assign merged_rtr  = merged[20];
   assign merged_ide  = merged[19];
   assign merged_extended_remote_mask = merged[0];

   // ---- checking helpers, read only by the properties below ----
   logic [7:0] gap_q, exp_factor;
   logic [5:0] s1_q, s2_q;
   logic       fell_q;
   logic [15:0] tim_prev_q;
   logic       chg_q, bchg_q;
   logic [5:0] len1_h, len2_h, sjw_h;
   logic [6:0] psc_h;

   assign psc_h      = timing_q[cbt_pkg::PSC_LSB +: cbt_pkg::PSC_W];
   assign exp_factor = (psc_h >= cbt_pkg::PSC_CAP_CODE) ? cbt_pkg::PSC_MAX_FACTOR
                                                        : {1'b0, psc_h} + cbt_pkg::PSC_OFFSET;
   assign len1_h = {2'b00, timing_q[cbt_pkg::TS1_LSB +: cbt_pkg::TS1_W]} + 6'h01;
   assign len2_h = {3'b000, timing_q[cbt_pkg::TS2_LSB +: cbt_pkg::TS2_W]} + 6'h01;
   assign sjw_h  = {4'b0000, timing_q[cbt_pkg::SJW_LSB +: cbt_pkg::SJW_W]} + 6'h01;

   // clocks since last quantum and quanta spent in segments one and two;
   // a timing write mid-quantum or mid-bit makes that span irregular, so flag it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q      <= 8'h00;
         s1_q       <= 6'h00;
         s2_q       <= 6'h00;
         fell_q     <= 1'b0;
         tim_prev_q <= cbt_pkg::TIMING_RST;
         chg_q      <= 1'b0;
         bchg_q     <= 1'b0;
      end else begin
         tim_prev_q <= timing_q;
         chg_q      <= !tq_tick && (chg_q || timing_q != tim_prev_q);
         bchg_q     <= (seg != cbt_pkg::SEG_SYNC) && (bchg_q || timing_q != tim_prev_q);
         gap_q  <= tq_tick ? 8'h00 : gap_q + 8'h01;
         s1_q   <= (seg != cbt_pkg::SEG_ONE) ? 6'h00 : s1_q + {5'h00, tq_tick};
         s2_q   <= (seg != cbt_pkg::SEG_TWO) ? 6'h00 : s2_q + {5'h00, tq_tick};
         fell_q <= (seg == cbt_pkg::SEG_SYNC) ? 1'b0 : (fell_q | rx_fall);
      end
   end

   chk_tq_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tq_tick && $stable(timing_q) && !chg_q && gap_q != 8'h00)
      |-> gap_q == exp_factor - 8'h01)
      else $error("quantum spacing differs from prescaler factor");

   chk_sync_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (seg == cbt_pkg::SEG_SYNC && tq_tick) |=> seg == cbt_pkg::SEG_ONE)
      else $error("sync quantum did not last one quantum");

   chk_seg1_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sample_pt && !fell_q && !rx_fall && $stable(timing_q) && !bchg_q)
      |-> s1_q + 6'h01 == len1_h)
      else $error("segment one length wrong without resync");

   chk_sjw_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (sample_pt && $stable(timing_q) && !bchg_q) |-> s1_q + 6'h01 <= len1_h + sjw_h)
      else $error("segment one stretched beyond jump width");

   chk_seg2_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (seg == cbt_pkg::SEG_TWO && tq_tick && $stable(timing_q) && !bchg_q && !fell_q
       && !rx_fall)
      |=> (seg == cbt_pkg::SEG_SYNC) == ($past(s2_q) + 6'h01 == len2_h))
      else $error("segment two length wrong without resync");

   chk_sample_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sample_pt |=> seg == cbt_pkg::SEG_TWO && rx_bit == $past(rx_s2_q))
      else $error("sample point did not capture bus level");

   chk_mask_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmp_valid && rx_ide && gmask == 32'h0000_0000) |=> acc_valid
      && accept == ($past(in_vec) == $past(buf_vec)))
      else $error("zero mask accept not exact compare");

   chk_mask_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmp_valid && gmask == 32'hFFFF_FFFF) |=> accept)
      else $error("all-ones mask still rejected a frame");

   chk_merge_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmp_valid && rx_ide && gmask == 32'hFFFF_FFFF)
      |=> merged_id == $past(rx_id) && merged_extended_remote_mask == $past(rx_extended_remote_mask))
       else $error("masked bits not overwritten by received ones");

   chk_std_lower: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cmp_valid && !rx_ide && gmask == 32'h0000_0000
       && (in_vec & cbt_pkg::STD_USED) == (buf_vec & cbt_pkg::STD_USED)) |=> accept)
      else $error("standard frame compared unused low bits");

   chk_mask_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == cbt_pkg::OFS_MASK_UP) ##1 (reg_rd && reg_addr == cbt_pkg::OFS_MASK_UP)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("upper mask read back wrong");

   cov_accept:  cover property (@(posedge sys_clk) disable iff (!rst_n) acc_valid && accept);
   cov_reject:  cover property (@(posedge sys_clk) disable iff (!rst_n) acc_valid && !accept);
   cov_resync:  cover property (@(posedge sys_clk) disable iff (!rst_n)
      seg == cbt_pkg::SEG_TWO && rx_fall);
   cov_sample:  cover property (@(posedge sys_clk) disable iff (!rst_n) sample_pt);
endmodule // cbt_core

/* File: verif/cbt_can_node.sv */
`timescale 1ns/1ps
// another node on the bus: idles recessive, on request drives one dominant stretch
module cbt_can_node (
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic [7:0] lead_clks,
   input  wire logic [7:0] hold_clks,
   output logic            can_rx
);
   // recessive is the pulled-up level, so an idle bus shows 1, never a stale value
   initial begin
      can_rx = 1'b1;
      forever begin
         @(posedge sys_clk);
         if (go === 1'b1) begin
            repeat (lead_clks) @(posedge sys_clk);
            can_rx <= 1'b0;    // falling edge placed where the bench aimed it
            repeat (hold_clks) @(posedge sys_clk);
            can_rx <= 1'b1;    // rising edge carries no resync
         end
      end
   end
endmodule // cbt_can_node

/* File: verif/can_bit_timing_and_global_mask_bench.sv */
`timescale 1ns/1ps
module can_bit_timing_and_global_mask_bench;
   logic        sys_clk   = 1'b0;
   logic        resetn    = 1'b0;
   logic [3:0]  reg_addr  = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] reg_rdata;
   logic        can_rx, tq_tick, sample_pt, rx_bit;
   logic        cmp_valid = 1'b0;
   logic [28:0] rx_id     = 29'h0;
   logic [28:0] buf_id    = 29'h0;
   logic        rx_ide = 1'b0, rx_rtr = 1'b0, rx_extended_remote_mask = 1'b0;
   logic        buf_ide = 1'b0, buf_rtr = 1'b0, buf_extended_remote_mask = 1'b0;
   logic        acc_valid, accept, merged_ide, merged_rtr, merged_extended_remote_mask;
   logic [28:0] merged_id;
   logic        node_go   = 1'b0;
   logic [7:0]  node_lead = 8'h1A;
   logic [7:0]  node_hold = 8'h3C;
   int          n_fail = 0;
   int          checked = 0;
   int          c, t;
   logic [15:0] rd, d, shadow [3];
   logic [31:0] gmask, bv, iv, m, rnd;
   logic [31:0] exp_mrg = 32'h0;
   logic [31:0] cmp_m = 32'h0;
   logic [3:0]  a;
   logic [6:0]  pcodes [6] = '{7'h00, 7'h01, 7'h05, 7'h7D, 7'h7E, 7'h7F};
   logic [6:0]  bt_p [4] = '{7'h00, 7'h03, 7'h7E, 7'h00};
   logic [3:0]  bt_a [4] = '{4'h1, 4'h2, 4'h1, 4'hF};
   logic [2:0]  bt_b [4] = '{3'h0, 3'h1, 3'h7, 3'h7};

   always #10 sys_clk = ~sys_clk;

   cbt_core DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .can_rx(can_rx), .tq_tick(tq_tick), .sample_pt(sample_pt), .rx_bit(rx_bit),
      .cmp_valid(cmp_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr),
      .rx_extended_remote_mask(rx_extended_remote_mask), .buf_id(buf_id), .buf_ide(buf_ide), .buf_rtr(buf_rtr),
      .buf_extended_remote_mask(buf_extended_remote_mask), .acc_valid(acc_valid), .accept(accept),
      .merged_id(merged_id), .merged_ide(merged_ide), .merged_rtr(merged_rtr),
      .merged_extended_remote_mask(merged_extended_remote_mask));

   cbt_can_node u_node (.sys_clk(sys_clk), .go(node_go), .lead_clks(node_lead),
      .hold_clks(node_hold), .can_rx(can_rx));

   task automatic report_and_stop();
      $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      checked++;
      if (got != exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] ad, input logic [15:0] dat);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= dat;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] ad, output logic [15:0] dat);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      dat = reg_rdata;
   endtask

   // clocks and quanta up to the next sample point (sp) or tick; bounded against a hang
   task automatic wait_ev(input bit sp, output int clks, output int ticks);
      clks  = 0;
      ticks = 0;
      do begin
         @(negedge sys_clk);
         clks++;
         ticks += int'(tq_tick === 1'b1);
      end while (((sp ? sample_pt : tq_tick) !== 1'b1) && clks < 4000);
      if (clks >= 4000) n_fail++;
   endtask

   function automatic logic [15:0] tword(input logic [6:0] p, input logic [1:0] s,
                                         input logic [3:0] s1, input logic [2:0] s2);
      return {p, s, s1, s2};
   endfunction

   function automatic int psc_factor(input logic [6:0] p);
      return (p >= 7'h7E) ? 128 : int'(p) + 2;
   endfunction

   // vectors follow the mask layout: id 28..18, remote, ide, id 17..0, extended remote
   task automatic do_compare(input logic [31:0] in_v, input logic [31:0] bf_v);
      logic [31:0] used;
      logic        ok;
      used = in_v[19] ? 32'hFFFF_FFFF : 32'hFFF8_0000;
      ok   = (((in_v ^ bf_v) & ~gmask & used) == 32'h0);
      if (ok) begin
         exp_mrg = (bf_v & ~(gmask & used)) | (in_v & gmask & used);
         cmp_m   = used;
      end
      @(posedge sys_clk);
      cmp_valid <= 1'b1;
      {rx_id[28:18], rx_rtr, rx_ide, rx_id[17:0], rx_extended_remote_mask}       <= in_v;
      {buf_id[28:18], buf_rtr, buf_ide, buf_id[17:0], buf_extended_remote_mask} <= bf_v;
      @(posedge sys_clk);
      cmp_valid <= 1'b0;
      @(negedge sys_clk);
      chk32({31'h0, acc_valid}, 32'h1);
      chk32({31'h0, accept}, {31'h0, ok});
      chk32({merged_id[28:18], merged_rtr, merged_ide, merged_id[17:0], merged_extended_remote_mask} & cmp_m,
            exp_mrg & cmp_m);
      @(negedge sys_clk);
      chk32({31'h0, acc_valid}, 32'h0);
   endtask

   // watchdog sized well past the longest expected run
   initial begin
      #1_500_000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      rnd = $urandom(32'hE54C39DE);
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      // reset values, random write and read-back, unmapped and read-only places
      for (int i = 0; i < 3; i++) begin
         reg_read(4'(2 * i), rd);
         chk16(rd, 16'h0000);
      end
      for (int i = 0; i < 9; i++) begin
         a = 4'(2 * (i % 3));
         d = 16'($urandom());
         shadow[i % 3] = d;
         reg_write(a, d);
         reg_read(a, rd);
         chk16(rd, d);
      end
      // write then read the upper mask with no gap between the strobes
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= cbt_pkg::OFS_MASK_UP;
      reg_wdata <= 16'hA5C3;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge sys_clk);
      reg_rd    <= 1'b0;
      @(negedge sys_clk);
      chk16(reg_rdata, 16'hA5C3);
      @(negedge sys_clk);
      chk16(reg_rdata, 16'h0000);
      reg_write(4'h8, 16'hFFFF);
      reg_write(cbt_pkg::OFS_STATUS, 16'hFFFF);
      reg_read(4'h8, rd);
      chk16(rd, 16'h0000);
      reg_read(cbt_pkg::OFS_STATUS, rd);
      chk16(rd & 16'hFFF0, 16'h0000);
      reg_read(cbt_pkg::OFS_MASK_LO, rd);
      chk16(rd, shadow[2]);
      $display("test registers done");
      // quantum length across prescaler codes, including both ceiling codes
      for (int i = 0; i < 6; i++) begin
         reg_write(cbt_pkg::OFS_TIMING, tword(pcodes[i], 2'b00, 4'h1, 3'h0));
         wait_ev(1'b0, c, t);
         wait_ev(1'b0, c, t);
         chk_n(c, psc_factor(pcodes[i]));
      end
      $display("test prescaler done");
      // nominal bit: sync quantum plus both segments, no edges on the bus
      for (int i = 0; i < 4; i++) begin
         reg_write(cbt_pkg::OFS_TIMING, tword(bt_p[i], 2'b00, bt_a[i], bt_b[i]));
         wait_ev(1'b1, c, t);
         wait_ev(1'b1, c, t);
         chk_n(t, 3 + int'(bt_a[i]) + int'(bt_b[i]));
         chk_n(c, psc_factor(bt_p[i]) * (3 + int'(bt_a[i]) + int'(bt_b[i])));
      end
      $display("test bit time done");
      // late edge deep in segment one stretches it by exactly the jump width
      for (int s = 0; s < 4; s++) begin
         reg_write(cbt_pkg::OFS_TIMING, tword(7'h00, 2'(s), 4'h7, 3'h7));
         wait_ev(1'b1, c, t);
         wait_ev(1'b1, c, t);
         @(posedge sys_clk);
         node_go <= 1'b1;
         @(posedge sys_clk);
         node_go <= 1'b0;
         wait_ev(1'b1, c, t);
         chk_n(t, 18 + s);
         @(negedge sys_clk);
         chk32({31'h0, rx_bit}, 32'h0);
         wait_ev(1'b1, c, t);
         wait_ev(1'b1, c, t);
         @(negedge sys_clk);
         chk32({31'h0, rx_bit}, 32'h1);
      end
      $display("test jump width done");
      // acceptance filter: hand-made corners first, then random frames
      for (int i = 0; i < 40; i++) begin
         bv = $urandom();
         m  = $urandom() & $urandom() & $urandom();
         iv = bv ^ ($urandom() & $urandom() & $urandom());
         if (i[0]) iv = bv ^ ($urandom() & m);
         case (i)
            0: m = 32'hFFFF_FFFF;
            1: begin m = 32'h0; iv = bv; end
            2: begin m = 32'h0; bv[19] = 1'b0; iv = bv ^ 32'h0007_FFFF; end
            3: begin m = 32'h0; bv[19] = 1'b1; iv = bv ^ 32'h1; end
            4: begin m = 32'h1; bv[19] = 1'b1; iv = bv ^ 32'h1; end
            5: begin m = 32'h0010_0000; bv[19] = 1'b0; iv = bv ^ 32'h0010_0000; end
            default: ;
         endcase
         gmask = m;
         reg_write(cbt_pkg::OFS_MASK_UP, m[31:16]);
         reg_write(cbt_pkg::OFS_MASK_LO, m[15:0]);
         do_compare(iv, bv);
      end
      $display("test filter done");
      report_and_stop();
   end
endmodule // can_bit_timing_and_global_mask_bench
